// ### verilog/oca_defs.vh
/*
 * Constants for the overcurrent alert output logic: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 125 MHz system clock; included by the design file only.
 */
`ifndef OCA_DEFS_VH
`define OCA_DEFS_VH

`define OCA_CLK_MHZ 125
`define OCA_WIN_US 10
`define OCA_WIN_CYC (`OCA_WIN_US * `OCA_CLK_MHZ)
`define OCA_SLEEP_US 20
`define OCA_SLEEP_CYC (`OCA_SLEEP_US * `OCA_CLK_MHZ)
`define OCA_WAKE_US 300
`define OCA_WAKE_CYC (`OCA_WAKE_US * `OCA_CLK_MHZ)

`define OCA_WINS_10US 4'h1
`define OCA_WINS_50US 4'h5
`define OCA_WINS_100US 4'hA

`define OCA_RTS_OPEN 2'h0
`define OCA_RTS_GND 2'h1
`define OCA_RTS_VS 2'h2

`define OCA_ADDR_CTRL 4'h0
`define OCA_ADDR_STATUS 4'h4
`define OCA_ADDR_IRQ_STAT 4'h8
`define OCA_ADDR_IRQ_MASK 4'hC

`define OCA_CTRL_EN_BIT 0
`define OCA_CTRL_RESET 1'h1
`define OCA_IRQ_W 4
`define OCA_IRQ_MASK_RESET 4'h0
`define OCA_IRQ_ASSERT_BIT 0
`define OCA_IRQ_RELEASE_BIT 1
`define OCA_IRQ_ACTIVE_BIT 2
`define OCA_IRQ_OFF_BIT 3

`define OCA_ST_OFF 2'h0
`define OCA_ST_WAKE 2'h1
`define OCA_ST_ACTIVE 2'h2
`define OCA_ST_SLEEP 2'h3

`endif

// ### verilog/oca_alert.v
/*
 * Overcurrent alert output logic with a classic Wishbone register slave:
 * control, status, interrupt status (write one to clear) and mask registers.
 * Assumes pins (comparator sample, mode, enable, response select) are
 * asynchronous and are synchronised here; the alert pin is open drain
 * with an external pull-up.
 */
// Contract
// - latch mode while hold_mode_select high, transparent while low
// - transparent mode: release flag after one 10 us window below threshold
// - latch mode: flag stays low after input falls below threshold
// - on mode low, release flag only if input below threshold
// - active while enable high, low-power disabled while enable low
// - low-power state reached about 20 us after enable falls
// - operation resumes about 300 us after enable rises; earlier decisions ignored
// - consecutive window counter cleared on disable, restarts on re-enable
// - free-running 10 us window, averaged over-limit decision at each end
// - response select: open 10 us, ground 50 us, supply 100 us
// - flag driven low on over-limit once response time is met
`include "oca_defs.vh"

module oca_alert #(
   parameter WAKE_CYC = `OCA_WAKE_CYC
) (
   input wire clk, // 125 MHz clock
   input wire resetn, // synchronous reset, active low
   input wire ce, // clock enable, freezes all state when low
   input wire wb_cyc_i, // wishbone cycle
   input wire wb_stb_i, // wishbone strobe
   input wire wb_we_i, // wishbone write enable
   input wire [3:0] wb_adr_i, // wishbone byte address
   input wire [3:0] wb_sel_i, // wishbone byte selects
   input wire [31:0] wb_dat_i, // wishbone write data
   output reg [31:0] wb_dat_o, // wishbone read data
   output wire wb_ack_o, // wishbone acknowledge
   output wire irq, // level interrupt, active high
   input wire over_limit_raw, // comparator sample, high when input above threshold
   input wire hold_mode_select, // mode pin, high selects latching
   input wire enable_pin, // enable pin, high selects active
   input wire [1:0] response_time_select, // level-detect code of response pin
   output wire overlimit_flag_n_o, // open-drain flag output value
   output wire overlimit_flag_n_oe // high while flag is pulled low
);

   localparam integer WIN_LAST_I = `OCA_WIN_CYC - 1;
   localparam integer WIN_HALF_I = `OCA_WIN_CYC / 2;
   localparam integer SLEEP_LAST_I = `OCA_SLEEP_CYC - 1;
   localparam integer WAKE_LAST_I = WAKE_CYC - 1;
   localparam [10:0] WIN_LAST = WIN_LAST_I[10:0];
   localparam [10:0] WIN_HALF = WIN_HALF_I[10:0];
   localparam [15:0] SLEEP_LAST = SLEEP_LAST_I[15:0];
   localparam [15:0] WAKE_LAST = WAKE_LAST_I[15:0];

   // two-stage synchronisers for every pin
   // only the second stage is read, so a metastable first stage never reaches logic
   reg [4:0] sync1_q;
   reg [4:0] sync2_q;
   wire over_s = sync2_q[0];
   wire latch_mode = sync2_q[1];
   wire en_pin_s = sync2_q[2];
   wire [1:0] rts_s = sync2_q[4:3];

   always @(posedge clk) begin
      if (!resetn) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end else if (ce) begin
         sync1_q <= {response_time_select, enable_pin, hold_mode_select, over_limit_raw};
         sync2_q <= sync1_q;
      end
   end

   // software enable is anded with the pin, so a bus write can also park the device
   reg ctrl_en_q;
   reg [`OCA_IRQ_W-1:0] irq_stat_q;
   reg [`OCA_IRQ_W-1:0] irq_mask_q;
   reg ack_q;

   // power state
   // wake and sleep share one timer, which only runs in those two states
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [15:0] tmr_q;
   reg [15:0] tmr_d;
   wire en_eff = en_pin_s & ctrl_en_q;

   always @* begin
      state_d = state_q;
      tmr_d = tmr_q + 16'h0001;
      case (state_q)
         `OCA_ST_OFF: begin
            tmr_d = 16'h0000;
            if (en_eff) state_d = `OCA_ST_WAKE;
         end
         `OCA_ST_WAKE: begin
            if (!en_eff) begin
               state_d = `OCA_ST_SLEEP;
               tmr_d = 16'h0000;
            end else if (tmr_q == WAKE_LAST) begin
               state_d = `OCA_ST_ACTIVE;
               tmr_d = 16'h0000;
            end
         end
         `OCA_ST_ACTIVE: begin
            tmr_d = 16'h0000;
            if (!en_eff) state_d = `OCA_ST_SLEEP;
         end
         `OCA_ST_SLEEP: begin
            if (en_eff) begin
               state_d = `OCA_ST_WAKE;
               tmr_d = 16'h0000;
            end else if (tmr_q == SLEEP_LAST) begin
               state_d = `OCA_ST_OFF;
               tmr_d = 16'h0000;
            end
         end
         default: begin
            state_d = `OCA_ST_OFF;
            tmr_d = 16'h0000;
         end
      endcase
   end

   always @(posedge clk) begin
      if (!resetn) begin
         state_q <= `OCA_ST_OFF;
         tmr_q <= 16'h0000;
      end else if (ce) begin
         state_q <= state_d;
         tmr_q <= tmr_d;
      end
   end

   wire active = (state_q == `OCA_ST_ACTIVE);

   // free-running averaging window
   reg [10:0] win_q;
   reg [10:0] win_d;
   reg [10:0] hi_q;
   reg [10:0] hi_d;
   wire win_end = (win_q == WIN_LAST);
   wire [10:0] hi_tot = hi_q + {10'h000, over_s};
   // majority vote of the samples stands in for the analog average
   wire win_over = win_end & (hi_tot > WIN_HALF);
   wire win_under = win_end & ~(hi_tot > WIN_HALF);

   // never paused by the power state, so response latency depends on input phase
   always @* begin
      win_d = win_q + 11'h001;
      hi_d = hi_tot;
      if (win_end) begin
         win_d = 11'h000;
         hi_d = 11'h000;
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         win_q <= 11'h000;
         hi_q <= 11'h000;
      end else if (ce) begin
         win_q <= win_d;
         hi_q <= hi_d;
      end
   end

   // response time in windows
   // code 3 is no legal strap; it falls back to the open setting
   reg [3:0] need;
   always @* begin
      case (rts_s)
         `OCA_RTS_GND: need = `OCA_WINS_50US;
         `OCA_RTS_VS: need = `OCA_WINS_100US;
         default: need = `OCA_WINS_10US;
      endcase
   end

   reg [3:0] consec_q;
   reg [3:0] consec_d;
   // saturate so a long overload cannot wrap the count and miss the trip
   wire [3:0] consec_nx = (consec_q == `OCA_WINS_100US) ? consec_q : consec_q + 4'h1;
   wire trip = active & win_over & (consec_nx >= need);

   always @* begin
      consec_d = consec_q;
      if (!active)
         consec_d = 4'h0;
      else if (win_over)
         consec_d = consec_nx;
      else if (win_under)
         consec_d = 4'h0;
   end

   always @(posedge clk) begin
      if (!resetn)
         consec_q <= 4'h0;
      else if (ce)
         consec_q <= consec_d;
   end

   // alert state; cleared outside ACTIVE, otherwise a clear needs the mode low and a window below threshold
   reg alert_q;
   reg alert_d;
   wire release_ok = active & win_under & ~latch_mode;
   always @* begin
      alert_d = alert_q;
      if (!active)
         alert_d = 1'b0;
      else if (trip)
         alert_d = 1'b1;
      else if (release_ok)
         alert_d = 1'b0;
   end

   always @(posedge clk) begin
      if (!resetn)
         alert_q <= 1'b0;
      else if (ce)
         alert_q <= alert_d;
   end

   // the pin only ever pulls low; the pull-up gives the idle level
   assign overlimit_flag_n_o = 1'b0;
   assign overlimit_flag_n_oe = alert_q;

   // event detection for interrupts
   reg alert_d1_q;
   reg [1:0] state_d1_q;
   wire [`OCA_IRQ_W-1:0] ev;
   assign ev[`OCA_IRQ_ASSERT_BIT] = alert_q & ~alert_d1_q;
   assign ev[`OCA_IRQ_RELEASE_BIT] = ~alert_q & alert_d1_q;
   assign ev[`OCA_IRQ_ACTIVE_BIT] = active & (state_d1_q != `OCA_ST_ACTIVE);
   assign ev[`OCA_IRQ_OFF_BIT] = (state_q == `OCA_ST_OFF) & (state_d1_q == `OCA_ST_SLEEP);

   always @(posedge clk) begin
      if (!resetn) begin
         alert_d1_q <= 1'b0;
         state_d1_q <= `OCA_ST_OFF;
      end else if (ce) begin
         alert_d1_q <= alert_q;
         state_d1_q <= state_q;
      end
   end

   // wishbone slave: one wait state, ack drops after one cycle
   // writes land at the edge that takes the request; ack rises at that same edge
   wire req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire wr0 = req & wb_we_i & wb_sel_i[0];
   assign wb_ack_o = ack_q;
   assign irq = |(irq_stat_q & irq_mask_q);

   wire [`OCA_IRQ_W-1:0] w1c = (wr0 && wb_adr_i == `OCA_ADDR_IRQ_STAT) ? wb_dat_i[`OCA_IRQ_W-1:0]
                                                                     : {`OCA_IRQ_W{1'b0}};

   // sticky bits, cleared by writing ones
   genvar gi;
   generate
      for (gi = 0; gi < `OCA_IRQ_W; gi = gi + 1) begin : g_irq
         // set wins over a write-one clear in the same cycle
         always @(posedge clk) begin
            if (!resetn)
               irq_stat_q[gi] <= 1'b0;
            else if (ce)
               irq_stat_q[gi] <= ev[gi] | (irq_stat_q[gi] & ~w1c[gi]);
         end
      end
   endgenerate

   // unmapped offsets read as zero and ignore writes
   reg [31:0] rd;
   always @* begin
      case (wb_adr_i)
         `OCA_ADDR_CTRL: rd = {31'h00000000, ctrl_en_q};
         `OCA_ADDR_STATUS: rd = {20'h00000, consec_q, rts_s, en_pin_s, latch_mode, state_q, active, alert_q};
         `OCA_ADDR_IRQ_STAT: rd = {28'h0000000, irq_stat_q};
         `OCA_ADDR_IRQ_MASK: rd = {28'h0000000, irq_mask_q};
         default: rd = 32'h00000000;
      endcase
   end

   always @(posedge clk) begin
      if (!resetn) begin
         ack_q <= 1'b0;
         wb_dat_o <= 32'h00000000;
         ctrl_en_q <= `OCA_CTRL_RESET;
         irq_mask_q <= `OCA_IRQ_MASK_RESET;
      end else if (ce) begin
         ack_q <= req;
         if (req & ~wb_we_i)
            wb_dat_o <= rd;
         if (wr0 && wb_adr_i == `OCA_ADDR_CTRL)
            ctrl_en_q <= wb_dat_i[`OCA_CTRL_EN_BIT];
         if (wr0 && wb_adr_i == `OCA_ADDR_IRQ_MASK)
            irq_mask_q <= wb_dat_i[`OCA_IRQ_W-1:0];
      end
   end

endmodule

// ### verification/oca_alert_sva.sv
/* assertions on the oca_alert ports
   assumes ce is held high by the bench */
module oca_alert_sva #(
   parameter WAKE_CYC = 20
) (
   input wire clk, // clock
   input wire resetn, // reset
   input wire wb_cyc_i, // cycle
   input wire wb_stb_i, // strobe
   input wire wb_ack_o, // ack
   input wire irq, // irq
   input wire over_limit_raw, // sample
   input wire hold_mode_select, // mode pin
   input wire enable_pin, // enable pin
   input wire [1:0] response_time_select, // delay code
   input wire overlimit_flag_n_oe // flag drive
);
   timeunit 1ns;
   timeprecision 1ps;
   int en_c = 0;
   int hi_c = 0;
   int lo_c = 0;
   // margins cover the two-flop pin synchronisers
   always @(posedge clk) begin
      en_c <= enable_pin ? en_c + 1 : 0;
      hi_c <= (over_limit_raw && response_time_select == 2'h0 && en_c > WAKE_CYC + 8) ? hi_c + 1 : 0;
      lo_c <= (!over_limit_raw && !hold_mode_select && enable_pin) ? lo_c + 1 : 0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
   property p_ack; s_req |=> s_ack; endproperty
   a_ack: assert property (p_ack) else $error("request not acked once");
   property p_ack_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ack_src: assert property (p_ack_src) else $error("ack without request");
   property p_rst; $rose(resetn) |-> !overlimit_flag_n_oe && !irq && !wb_ack_o; endproperty
   a_rst: assert property (p_rst) else $error("outputs active after reset");
   property p_wake; $rose(overlimit_flag_n_oe) |-> en_c > WAKE_CYC; endproperty
   a_wake: assert property (p_wake) else $error("alert before wake done");
   property p_off; !enable_pin [*6] |-> !overlimit_flag_n_oe; endproperty
   a_off: assert property (p_off) else $error("alert while disabled");
   property p_latch; (hold_mode_select && enable_pin && overlimit_flag_n_oe) [*5] |=> overlimit_flag_n_oe; endproperty
   a_latch: assert property (p_latch) else $error("latched alert dropped");
   property p_trans; lo_c == 2600 |-> !overlimit_flag_n_oe; endproperty
   a_trans: assert property (p_trans) else $error("alert not released");
   property p_trip; hi_c == 2600 |-> overlimit_flag_n_oe; endproperty
   a_trip: assert property (p_trip) else $error("alert not raised");
endmodule

bind oca_alert oca_alert_sva #(.WAKE_CYC(WAKE_CYC)) i_oca_alert_sva (.clk(clk), .resetn(resetn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq(irq), .over_limit_raw(over_limit_raw),
   .hold_mode_select(hold_mode_select), .enable_pin(enable_pin), .response_time_select(response_time_select),
   .overlimit_flag_n_oe(overlimit_flag_n_oe));

// ### verification/oca_ctrl_model.sv
/* system controller: drives mode and enable pins, sees the flag
   assumes a pull-up on the open-drain flag */
module oca_ctrl_model (
   input wire clk, // clock
   input wire flag_o, // flag value
   input wire flag_oe, // flag drive
   input wire en_req, // wanted enable
   input wire latch_req, // wanted latching
   input wire clear_req, // starts a clear
   output logic enable_pin = 1'h0, // enable pin
   output logic hold_mode_select = 1'h0, // mode pin
   output wire flag_n // flag pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int clr_c = 0;
   assign flag_n = flag_oe ? flag_o : 1'h1;
   always @(posedge clk) begin
      if (clear_req)
         clr_c <= 2500;
      else if (clr_c > 0)
         clr_c <= clr_c - 1;
      enable_pin <= en_req;
      hold_mode_select <= latch_req && clr_c == 0 && !clear_req;
   end
endmodule

// ### verification/testbench.sv
/* self-checking bench for oca_alert
   assumes the controller model and a shortened wake count */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WAKE = 20;
   localparam int WIN = 1250;
   logic clk = 0, resetn = 0, ce = 1, cyc = 0, stb = 0, we = 0, over = 0;
   logic en_req = 0, latch_req = 0, clear_req = 0;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0, q, rnd;
   logic [1:0] rts = 2'h0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, irq, flag_o, flag_oe, enable_pin, hold_mode_select, flag_n;
   int errors = 0, n_checks = 0, seed = 28055, t;
   always #4 clk = ~clk;
   oca_alert #(.WAKE_CYC(WAKE)) i_oca_alert (.clk(clk), .resetn(resetn), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .irq(irq), .over_limit_raw(over), .hold_mode_select(hold_mode_select), .enable_pin(enable_pin),
      .response_time_select(rts), .overlimit_flag_n_o(flag_o), .overlimit_flag_n_oe(flag_oe));
   oca_ctrl_model i_oca_ctrl_model (.clk(clk), .flag_o(flag_o), .flag_oe(flag_oe), .en_req(en_req),
      .latch_req(latch_req), .clear_req(clear_req), .enable_pin(enable_pin),
      .hold_mode_select(hold_mode_select), .flag_n(flag_n));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      dat <= d;
      do @(posedge clk); while (wb_ack_o !== 1'h1);
      q = wb_dat_o;
      cyc <= 0;
      stb <= 0;
      @(posedge clk);
   endtask
   task wait_flag(input logic lvl, input int lim);
      t = 0;
      while (flag_n !== lvl && t < lim) begin
         @(posedge clk);
         t++;
      end
   endtask
   function int wins(input logic [1:0] r);
      return r == 2'h0 ? 1 : r == 2'h1 ? 5 : 10;
   endfunction
   task final_report;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk);
      errors++;
      final_report;
   end
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1;
      @(posedge clk);
      wb(0, 4'h0, 0);
      chk("ctrl", q, 32'h1);
      wb(0, 4'h2, 0);
      chk("unmapped", q, 32'h0);
      en_req <= 1;
      repeat (WAKE + 50) @(posedge clk);
      wb(0, 4'h4, 0);
      chk("state", q[3:2], 2'h2);
      chk("irq masked", irq, 1'h0);
      rnd = $random(seed);
      wb(1, 4'hC, rnd);
      wb(0, 4'hC, 0);
      chk("mask", q, {28'h0, rnd[3:0]});
      chk("irq mix", irq, rnd[2]);
      wb(1, 4'hC, 32'hF);
      chk("irq on", irq, 1'h1);
      wb(1, 4'h8, 32'hF);
      chk("irq off", irq, 1'h0);
      $display("bus test done");
      for (int r = 0; r < 3; r++) begin
         rts <= r[1:0];
         repeat ($random(seed) & 32'h3FF) @(posedge clk);
         over <= 1;
         wait_flag(0, (wins(r[1:0]) + 1) * WIN + 20);
         chk("trip", t > (wins(r[1:0]) - 1) * WIN && t < (wins(r[1:0]) + 1) * WIN + 10, 1'h1);
         over <= 0;
         wait_flag(1, 2 * WIN + 20);
         chk("release", flag_n, 1'h1);
         wb(0, 4'h8, 0);
         chk("events", q[1:0], 2'h3);
         wb(1, 4'h8, 32'hF);
         chk("irq w1c", irq, 1'h0);
         $display("response test done");
      end
      rts <= 2'h0;
      latch_req <= 1;
      over <= 1;
      wait_flag(0, 2 * WIN + 20);
      over <= 0;
      repeat (3 * WIN) @(posedge clk);
      chk("latched", flag_n, 1'h0);
      over <= 1;
      clear_req <= 1;
      @(posedge clk);
      clear_req <= 0;
      repeat (2700) @(posedge clk);
      chk("still over", flag_n, 1'h0);
      over <= 0;
      repeat (WIN + 20) @(posedge clk);
      clear_req <= 1;
      @(posedge clk);
      clear_req <= 0;
      wait_flag(1, 2600);
      chk("cleared", flag_n, 1'h1);
      latch_req <= 0;
      rts <= 2'h2;
      over <= 1;
      repeat (7 * WIN) @(posedge clk);
      rts <= 2'h1;
      wait_flag(0, WIN + 20);
      chk("trip 50", flag_n, 1'h0);
      en_req <= 0;
      repeat (100) @(posedge clk);
      chk("dis flag", flag_n, 1'h1);
      wb(0, 4'h4, 0);
      chk("sleep", q[3:2], 2'h3);
      repeat (2500) @(posedge clk);
      wb(0, 4'h4, 0);
      chk("off", q[3:2], 2'h0);
      rts <= 2'h2;
      en_req <= 1;
      repeat (WAKE + 30 + 8 * WIN) @(posedge clk);
      chk("restart", flag_n, 1'h1);
      wait_flag(0, 3 * WIN);
      chk("trip again", flag_n, 1'h0);
      over <= 0;
      $display("mode test done");
      final_report;
   end
endmodule
